// >>> pkg/eqw_pkg.sv
// Package for the two-wire EEPROM write path with quadrant locking.
// Assumes a 50 MHz block clock and a partner-driven serial clock.
`default_nettype none

package eqw_pkg;

   // Block clock and programming time
   localparam int unsigned CLK_MHZ          = 50;
   localparam int unsigned PROG_TIME_MAX_US = 5000;   // programming_time_max
   localparam int unsigned PROG_CYCLES      = PROG_TIME_MAX_US * CLK_MHZ;
   localparam int unsigned PCNT_W           = 18;

   // Device address byte fields
   localparam logic [3:0] DEV_ARRAY  = 4'ha;          // Array access type
   localparam logic [3:0] DEV_PROT   = 4'h6;          // Protection type
   localparam logic [2:0] CLR_CODE   = 3'h3;          // Lock clear code
   localparam logic [2:0] QID_Q0     = 3'h1;          // Quadrant identifiers
   localparam logic [2:0] QID_Q1     = 3'h4;
   localparam logic [2:0] QID_Q2     = 3'h5;
   localparam logic [2:0] QID_Q3     = 3'h0;

   // Page geometry and reset values
   localparam int unsigned PAGE_BYTES = 16;
   localparam logic [3:0]  BIT_LAST   = 4'h8;         // Bits per byte
   localparam logic [3:0]  LOCK_RESET = 4'h0;

   typedef enum logic [2:0] {
      PH_IDLE, PH_DEV, PH_WORD, PH_DATA, PH_SKIP
   } eqw_phase_t;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_ARRAY, CMD_SET, CMD_CLR, CMD_QRY
   } eqw_cmd_t;

   // Array programming port
   typedef struct packed {
      logic       we;
      logic [8:0] addr;
      logic [7:0] data;
   } eqw_mem_wr_t;

   // Whole block state
   typedef struct packed {
      logic              scl_s1, scl_s2, scl_s3;
      logic              sda_s1, sda_s2, sda_s3;
      logic              hv_s1, hv_s2;
      logic [2:0]        hwa_s1, hwa_s2;
      eqw_phase_t        phase;
      eqw_cmd_t          cmd;
      logic [3:0]        bcnt;
      logic              ack_slot;
      logic [7:0]        shreg;
      logic [1:0]        quad;
      logic [7:0]        addr;
      logic              half;
      logic [15:0][7:0]  page;
      logic [15:0]       valid;
      logic              armed;
      logic              busy;
      logic [PCNT_W-1:0] pcnt;
      logic              sda_out;
      logic              sda_oe;
      eqw_mem_wr_t       mem;
      logic [3:0]        lock;
   } eqw_state_t;

endpackage

`default_nettype wire

// >>> src/eqw_write_lock.sv
// Write path of a 512-byte two-wire EEPROM slave with quadrant locks.
// Assumes scl/sda/hv/address pins come from outside this clock domain;
// half_select_i comes from neighbouring logic on the same clock.
//
// What this block does
// - Write is Start, address byte with write bit, word address, data.
// - Locked quadrant: data byte refused, no cycle; set on locked refused.
// - Byte write: ack address, word, data; Stop starts timed programming.
// - During programming all bus inputs are ignored, no response.
// - Page write stores 1 to 16 bytes sharing address bits 7..4.
// - Further data bytes each acked; closing Stop starts programming.
// - Only low four address bits increment, wrapping within the page.
// - Address bytes refused while programming, acked once finished.
// - Array accesses during the programming interval are not processed.
// - Quadrant identifiers 001, 100, 101, 000 map quadrants 0 to 3.
// - Lock set is 0110 MMM 0 with high voltage; locks one quadrant.
// - Lock persists until lock clear or reset; either unlocks all four.
// - Lock clear is 01100110 with high voltage, two bytes, Stop.
// - Lock query acks address if unlocked; refuses next two bytes.
// - Array type bits 1010, protection type bits 0110.
`default_nettype none

module eqw_write_lock
   import eqw_pkg::*;
#(
   parameter int unsigned PROG_CYCLES_P = eqw_pkg::PROG_CYCLES
) (
   input  wire logic                 ref_clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   input  wire logic                 hv_i,
   input  wire logic [2:0]           hw_addr_i,
   input  wire logic                 half_select_i,
   output var  logic                 sda_o,
   output var  logic                 sda_oe_o,
   output var  logic                 busy_o,
   output var  logic [3:0]           lock_o,
   output var  eqw_pkg::eqw_mem_wr_t mem_o
);
   import eqw_pkg::*;

   // Programming time must cover the page walk and fit the counter
   if (PROG_CYCLES_P <= PAGE_BYTES || PROG_CYCLES_P >= (1 << PCNT_W)) begin
      $error("PROG_CYCLES_P out of range");
   end

   localparam logic [PCNT_W-1:0] PCNT_LAST =
      PCNT_W'(PROG_CYCLES_P - 1);
   localparam logic [PCNT_W-1:0] PCNT_PAGE = PCNT_W'(PAGE_BYTES);

   eqw_state_t st_q;
   eqw_state_t st_d;

   ////////////////////////////////////////////////////////////////////////
   // Quadrant identifier decode

   // Identifier code to quadrant index, with a validity flag
   function automatic logic [2:0] quad_decode(input logic [2:0] code);
      logic [2:0] r;
      r = 3'h0;
      case (code)
         QID_Q0:  r = 3'h4;
         QID_Q1:  r = 3'h5;
         QID_Q2:  r = 3'h6;
         QID_Q3:  r = 3'h7;
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus events from the synchronised pins

   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;
   logic [2:0] qdec;
   logic [1:0] arr_quad;

   // Edges and Start/Stop seen on the second and third stages
   assign scl_rise = st_q.scl_s2 & ~st_q.scl_s3;
   assign scl_fall = ~st_q.scl_s2 & st_q.scl_s3;
   assign start_ev = st_q.scl_s2 & st_q.scl_s3 & st_q.sda_s3 & ~st_q.sda_s2;
   assign stop_ev  = st_q.scl_s2 & st_q.scl_s3 & ~st_q.sda_s3 & st_q.sda_s2;
   assign qdec     = quad_decode(st_q.shreg[3:1]);
   assign arr_quad = {st_q.half, st_q.addr[7]};

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      st_d        = st_q;
      st_d.scl_s1 = scl_i;
      st_d.scl_s2 = st_q.scl_s1;
      st_d.scl_s3 = st_q.scl_s2;
      st_d.sda_s1 = sda_i;
      st_d.sda_s2 = st_q.sda_s1;
      st_d.sda_s3 = st_q.sda_s2;
      st_d.hv_s1  = hv_i;
      st_d.hv_s2  = st_q.hv_s1;
      st_d.hwa_s1 = hw_addr_i;
      st_d.hwa_s2 = st_q.hwa_s1;
      st_d.mem.we = 1'b0;
      st_d.sda_out = 1'b0;

      if (st_q.busy) begin
         // Self-timed cycle; bus is not looked at
         st_d.pcnt = st_q.pcnt + 1'b1;
         if (st_q.cmd == CMD_ARRAY && st_q.pcnt < PCNT_PAGE) begin
            st_d.mem.we   = st_q.valid[st_q.pcnt[3:0]];
            st_d.mem.addr = {st_q.half, st_q.addr[7:4], st_q.pcnt[3:0]};
            st_d.mem.data = st_q.page[st_q.pcnt[3:0]];
         end
         if (st_q.pcnt == PCNT_LAST) begin
            st_d.busy  = 1'b0;
            st_d.armed = 1'b0;
            st_d.valid = '0;
         end
      end else if (stop_ev) begin
         // Stop ends the transfer and launches an armed cycle
         st_d.phase    = PH_IDLE;
         st_d.sda_oe   = 1'b0;
         st_d.ack_slot = 1'b0;
         if (st_q.armed) begin
            st_d.busy = 1'b1;
            st_d.pcnt = '0;
            if (st_q.cmd == CMD_SET) begin
               st_d.lock[st_q.quad] = 1'b1;
            end
            if (st_q.cmd == CMD_CLR) begin
               st_d.lock = '0;
            end
         end
      end else if (start_ev) begin
         // Start, repeated or not, drops anything not yet launched
         st_d.phase    = PH_DEV;
         st_d.cmd      = CMD_NONE;
         st_d.bcnt     = '0;
         st_d.ack_slot = 1'b0;
         st_d.sda_oe   = 1'b0;
         st_d.armed    = 1'b0;
         st_d.valid    = '0;
      end else if (st_q.phase != PH_IDLE) begin
         // Shift in one bit per rising serial clock
         if (scl_rise && !st_q.ack_slot && st_q.bcnt != BIT_LAST) begin
            st_d.shreg = {st_q.shreg[6:0], st_q.sda_s2};
            st_d.bcnt  = st_q.bcnt + 1'b1;
         end
         if (scl_fall && st_q.ack_slot) begin
            // End of acknowledge slot: release the line
            st_d.ack_slot = 1'b0;
            st_d.sda_oe   = 1'b0;
            st_d.bcnt     = '0;
         end else if (scl_fall && st_q.bcnt == BIT_LAST) begin
            // Byte complete: decide acknowledge and next phase
            st_d.ack_slot = 1'b1;
            st_d.sda_oe   = 1'b0;
            st_d.phase    = PH_SKIP;
            case (st_q.phase)
               PH_DEV: begin
                  if (st_q.shreg[7:4] == DEV_ARRAY &&
                      st_q.shreg[3:1] == st_q.hwa_s2 &&
                      !st_q.shreg[0]) begin
                     st_d.cmd    = CMD_ARRAY;
                     st_d.sda_oe = 1'b1;
                     st_d.phase  = PH_WORD;
                  end else if (st_q.shreg[7:4] == DEV_PROT) begin
                     if (!st_q.shreg[0] && st_q.hv_s2 &&
                         st_q.shreg[3:1] == CLR_CODE) begin
                        st_d.cmd    = CMD_CLR;
                        st_d.sda_oe = 1'b1;
                        st_d.phase  = PH_WORD;
                     end else if (qdec[2] && !st_q.shreg[0] &&
                                  st_q.hv_s2 &&
                                  !st_q.lock[qdec[1:0]]) begin
                        st_d.cmd    = CMD_SET;
                        st_d.quad   = qdec[1:0];
                        st_d.sda_oe = 1'b1;
                        st_d.phase  = PH_WORD;
                     end else if (qdec[2] && st_q.shreg[0]) begin
                        st_d.cmd    = CMD_QRY;
                        st_d.sda_oe = !st_q.lock[qdec[1:0]];
                     end
                  end
               end
               PH_WORD: begin
                  st_d.sda_oe = 1'b1;
                  st_d.phase  = PH_DATA;
                  if (st_q.cmd == CMD_ARRAY) begin
                     st_d.addr = st_q.shreg;
                     st_d.half = half_select_i;
                  end
               end
               PH_DATA: begin
                  if (st_q.cmd == CMD_ARRAY) begin
                     if (st_q.lock[arr_quad]) begin
                        st_d.armed = 1'b0;
                     end else begin
                        st_d.page[st_q.addr[3:0]]  = st_q.shreg;
                        st_d.valid[st_q.addr[3:0]] = 1'b1;
                        st_d.addr[3:0] = st_q.addr[3:0] + 1'b1;
                        st_d.armed  = 1'b1;
                        st_d.sda_oe = 1'b1;
                        st_d.phase  = PH_DATA;
                     end
                  end else if (st_q.hv_s2) begin
                     st_d.armed  = 1'b1;
                     st_d.sda_oe = 1'b1;
                  end else begin
                     st_d.armed  = 1'b0;
                  end
               end
               default: begin
                  st_d.sda_oe = 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         st_q          <= '0;
         st_q.scl_s1   <= 1'b1;
         st_q.scl_s2   <= 1'b1;
         st_q.scl_s3   <= 1'b1;
         st_q.sda_s1   <= 1'b1;
         st_q.sda_s2   <= 1'b1;
         st_q.sda_s3   <= 1'b1;
         st_q.phase    <= PH_IDLE;
         st_q.cmd      <= CMD_NONE;
         st_q.lock     <= LOCK_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign sda_o    = st_q.sda_out;
   assign sda_oe_o = st_q.sda_oe;
   assign busy_o   = st_q.busy;
   assign lock_o   = st_q.lock;
   assign mem_o    = st_q.mem;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   a_busy_no_ack: assert property (st_q.busy |-> !st_q.sda_oe)
      else $error("line driven while programming");

   // Phase is parked at idle by the Stop that raised busy
   a_busy_silent: assert property (
      st_q.busy && $past(st_q.busy) |-> $stable(st_q.phase))
      else $error("bus state moved while programming");

   a_cycle_start: assert property (
      !st_q.busy && stop_ev && st_q.armed |=> st_q.busy ##1 st_q.busy)
      else $error("armed stop did not start programming");

   a_no_cycle: assert property (
      !st_q.busy && stop_ev && !st_q.armed |=> !st_q.busy)
      else $error("programming started without armed write");

   a_locked_we: assert property (
      st_q.mem.we |-> !st_q.lock[st_q.mem.addr[8:7]] && st_q.busy)
      else $error("write into locked quadrant");

   a_clear_all: assert property (
      !st_q.busy && stop_ev && st_q.armed && st_q.cmd == CMD_CLR
      |=> st_q.lock == 4'h0)
      else $error("lock clear left a quadrant locked");

   a_set_one: assert property (
      !st_q.busy && stop_ev && st_q.armed && st_q.cmd == CMD_SET
      |=> st_q.lock == ($past(st_q.lock) | (4'h1 << $past(st_q.quad))))
      else $error("lock set changed wrong quadrant");

   a_locked_nack: assert property (
      !st_q.busy && !stop_ev && !start_ev && scl_fall && !st_q.ack_slot &&
      st_q.bcnt == BIT_LAST && st_q.phase == PH_DATA &&
      st_q.cmd == CMD_ARRAY && st_q.lock[arr_quad]
      |=> !st_q.sda_oe && !st_q.armed)
      else $error("data into locked quadrant acknowledged");

   a_page_wrap: assert property (
      !st_q.busy && !stop_ev && !start_ev && scl_fall && !st_q.ack_slot &&
      st_q.bcnt == BIT_LAST && st_q.phase == PH_DATA &&
      st_q.cmd == CMD_ARRAY && !st_q.lock[arr_quad]
      |=> st_q.addr[7:4] == $past(st_q.addr[7:4]) &&
          st_q.addr[3:0] == $past(st_q.addr[3:0]) + 4'h1)
      else $error("page address did not wrap in page");

   // Any byte after a refused or query address byte is refused
   a_query_nack: assert property (
      !st_q.busy && !stop_ev && !start_ev && scl_fall && !st_q.ack_slot &&
      st_q.bcnt == BIT_LAST && st_q.phase == PH_SKIP
      |=> !st_q.sda_oe)
      else $error("query byte after address acknowledged");

endmodule

`default_nettype wire

// >>> tb/eqw_bus_master.sv
// Two-wire bus master model: makes the serial clock, drives the data line.
// Assumes the block clock paces it and the data line has a pull-up.
`default_nettype none

module eqw_bus_master (
   input  wire logic ref_clk_i,
   input  wire logic sda_oe_i,
   output var  logic scl_o,
   output var  logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic drv;

   // Open drain with pull-up: low when either party pulls
   assign sda_o = drv & ~sda_oe_i;

   // Clock stands high outside frames
   initial begin
      scl_o = 1'b1;
      drv   = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Every change lands just after a block clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   // Data falls while the clock is high
   task automatic start();
      drv = 1'b0;
      tick(4);
      scl_o = 1'b0;
      tick(4);
   endtask

   // Data rises while the clock is high
   task automatic stop();
      drv = 1'b0;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      drv = 1'b1;
      tick(4);
   endtask

   // Eight bits, then the ninth clock samples the answer
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         drv = b[i];
         tick(3);
         scl_o = 1'b1;
         tick(4);
         scl_o = 1'b0;
         tick(1);
      end
      drv = 1'b1;
      tick(3);
      scl_o = 1'b1;
      tick(2);
      ack = ~sda_o;
      tick(2);
      scl_o = 1'b0;
      tick(1);
   endtask
endmodule

`default_nettype wire

// >>> tb/tb_eqw_write_lock.sv
// Testbench for the EEPROM write path with quadrant locks.
// Assumes the bus master model drives the pins; straps stay fixed.
`default_nettype none

module tb_eqw_write_lock;
   timeunit 1ns;
   timeprecision 1ps;
   import eqw_pkg::*;

   localparam int unsigned PC = 400;
   localparam logic [2:0]  HW = 3'h5;
   localparam logic [7:0]  WDEV = {4'ha, HW, 1'b0};

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hv = 1'b0;
   logic        half = 1'b0;
   logic        scl;
   logic        sda;
   logic        oe;
   logic        sdo;
   logic        busy;
   logic [3:0]  lock;
   logic [3:0]  exp_lock = 4'h0;
   eqw_mem_wr_t mem;
   logic [7:0]  img [512];
   logic [7:0]  ref_mem [512];
   logic [2:0]  qid [4] = '{3'h1, 3'h4, 3'h5, 3'h0};
   int          n_mismatch = 0;
   int          comparisons = 0;

   always #10 clk = ~clk;

   eqw_write_lock #(.PROG_CYCLES_P(PC)) dut (
      .ref_clk_i(clk), .reset_i(rst), .scl_i(scl), .sda_i(sda), .hv_i(hv),
      .hw_addr_i(HW), .half_select_i(half), .sda_o(sdo), .sda_oe_o(oe),
      .busy_o(busy), .lock_o(lock), .mem_o(mem));

   eqw_bus_master mst (.ref_clk_i(clk), .sda_oe_i(oe), .scl_o(scl),
      .sda_o(sda));

   // Array image built from the programming port
   always @(posedge clk) begin
      if (mem.we === 1'b1)
         img[mem.addr] <= mem.data;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One frame: address, word address, data; then programming or not
   task automatic op(input logic [7:0] dev, input logic [7:0] wa,
                     input int nb, input logic [7:0] d0,
                     input logic [17:0] exp, input logic prog);
      logic [17:0] got;
      logic        a;
      int          k;
      got = '0;
      mst.start();
      for (k = 0; k < nb; k++) begin
         mst.send(k == 0 ? dev : (k == 1 ? wa : 8'(d0 + k - 2)), a);
         got[k] = a;
      end
      mst.stop();
      check(32'(got), 32'(exp), "ack pattern");
      if (prog && dev[7:4] == 4'ha) begin
         for (k = 2; k < nb; k++)
            ref_mem[{half, wa[7:4], wa[3:0] + 4'(k - 2)}] = 8'(d0 + k - 2);
      end
      if (prog) begin
         check(32'(busy), 32'h1, "busy after stop");
         mst.start();
         mst.send(WDEV, a);
         mst.stop();
         check(32'(a), 32'h0, "poll while busy");
         k = 0;
         while (busy !== 1'b0 && k < PC + 20) begin
            tick(1);
            k++;
         end
         check(32'(busy), 32'h0, "busy end");
         k = 0;
         for (int i = 0; i < 512; i++) begin
            if (img[i] !== ref_mem[i])
               k++;
         end
         check(32'(k), 32'h0, "array image");
         mst.start();
         mst.send(WDEV, a);
         mst.stop();
         check(32'(a), 32'h1, "poll after cycle");
      end else begin
         tick(20);
         check(32'(busy), 32'h0, "no cycle");
      end
      check(32'(lock), 32'(exp_lock), "lock flags");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung handshake
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end

   // Main sequence
   initial begin
      for (int i = 0; i < 512; i++) begin
         img[i] = 8'h00;
         ref_mem[i] = 8'h00;
      end
      tick(2);
      rst = 1'b0;
      tick(1);
      check(32'({sdo, oe, busy, lock}), 32'h0, "reset outputs");
      tick(3);
      op(WDEV, 8'h25, 3, 8'ha5, 18'h7, 1'b1);
      op(WDEV, 8'h3d, 18, 8'h10, 18'h3ffff, 1'b1);
      half = 1'b1;
      op(WDEV, 8'h85, 3, 8'h5a, 18'h7, 1'b1);
      half = 1'b0;
      $display("test array writes done");
      exp_lock = 4'h2;
      hv = 1'b1;
      op({4'h6, qid[1], 1'b0}, 8'h00, 3, 8'h00, 18'h7, 1'b1);
      op({4'h6, qid[1], 1'b0}, 8'h00, 3, 8'h00, 18'h0, 1'b0);
      op(WDEV, 8'h90, 4, 8'h33, 18'h3, 1'b0);
      op(WDEV, 8'h10, 3, 8'h44, 18'h7, 1'b1);
      hv = 1'b0;
      op({4'h6, qid[0], 1'b0}, 8'h00, 3, 8'h00, 18'h0, 1'b0);
      hv = 1'b1;
      for (int q = 0; q < 4; q++) begin
         exp_lock[q] = 1'b1;
         op({4'h6, qid[q], 1'b0}, 8'h00, 3, 8'h00, q == 1 ? 18'h0 : 18'h7,
            q != 1);
      end
      hv = 1'b0;
      for (int q = 0; q < 4; q++) begin
         half = q[1];
         op(WDEV, q[0] ? 8'hc0 : 8'h40, 3, 8'h77, 18'h3, 1'b0);
         op({4'h6, qid[q], 1'b1}, 8'h00, 3, 8'h00, 18'h0, 1'b0);
      end
      $display("test lock set done");
      hv = 1'b1;
      exp_lock = 4'h0;
      op({4'h6, 3'h3, 1'b0}, 8'h00, 3, 8'h00, 18'h7, 1'b1);
      hv = 1'b0;
      for (int q = 0; q < 4; q++)
         op({4'h6, qid[q], 1'b1}, 8'h00, 3, 8'h00, 18'h1, 1'b0);
      half = 1'b0;
      op(WDEV, 8'h9f, 4, 8'h61, 18'hf, 1'b1);
      $display("test lock clear done");
      close_out();
   end
endmodule

`default_nettype wire
